/* File: src/nsi_integrator.sv */
// Negative sequence thermal integrator with definite minimum time and warning stage.
// Assumes i2_mag and settings come from logic on clk_sys; block_input is asynchronous.
`timescale 1ns/1ps
module nsi_integrator
  import nsi_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Measurement, 0.1 % of transformer rated current
  input wire logic [CUR_W-1:0] i2_mag,
  // Blocking from user logic
  input wire logic block_input,
  // Setting set, captured on param_load
  input wire logic param_load,
  input wire logic function_enable_setting,
  input wire logic start_only_setting,
  input wire logic [SET_W-1:0] gen_rated_setting,
  input wire logic [SET_W-1:0] k_setting,
  input wire logic [SET_W-1:0] cooling_time_setting,
  input wire logic [SET_W-1:0] warn_level_setting,
  input wire logic [SET_W-1:0] integ_level_setting,
  input wire logic [SET_W-1:0] warn_delay_setting,
  input wire logic [SET_W-1:0] min_delay_setting,
  // Status
  output logic general_start_out,
  output logic general_trip_out,
  output logic warning_start_out,
  output logic warning_trip_out,
  output logic [PCT_W-1:0] integral_pct
);
  localparam int TC_W = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // Settings register
  logic en_set;
  logic so_set;
  logic [SET_W-1:0] gen_set;
  logic [SET_W-1:0] k_set;
  logic [SET_W-1:0] cool_set;
  logic [SET_W-1:0] warn_lvl;
  logic [SET_W-1:0] int_lvl;
  logic [SET_W-1:0] warn_del;
  logic [SET_W-1:0] min_del;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_set <= ENABLE_RST; // [R12]
      so_set <= START_ONLY_RST; // [R13]
      gen_set <= GEN_RATED_RST;
      k_set <= K_RST;
      cool_set <= COOL_RST;
      warn_lvl <= WARN_LVL_RST;
      int_lvl <= INTEG_LVL_RST;
      warn_del <= WARN_DEL_RST;
      min_del <= MIN_DEL_RST;
    end else if (param_load) begin
      en_set <= function_enable_setting;
      so_set <= start_only_setting;
      gen_set <= gen_rated_setting;
      k_set <= k_setting;
      cool_set <= cooling_time_setting;
      warn_lvl <= warn_level_setting;
      int_lvl <= integ_level_setting;
      warn_del <= warn_delay_setting;
      min_del <= min_delay_setting;
    end
  end

  // ==========================================================
  // Block input synchroniser and millisecond tick
  logic blk_meta;
  logic blk_sync;
  logic [TC_W-1:0] tick_cnt;
  logic tick;
  wire tick_wrap = (tick_cnt == TC_W'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      blk_meta <= 1'b0;
      blk_sync <= 1'b0;
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      blk_meta <= block_input;
      blk_sync <= blk_meta;
      tick_cnt <= tick_wrap ? '0 : tick_cnt + TC_W'(1);
      tick <= tick_wrap;
    end
  end

  // ==========================================================
  // Level comparisons, all relative to generator rated current
  wire gate = en_set & ~blk_sync; // [R12] [R14]
  wire [SQ_W-1:0] i2_x1000 = SQ_W'(i2_mag) * SQ_W'(PER_MILLE);
  wire [SQ_W-1:0] int_thr = SQ_W'(int_lvl) * SQ_W'(gen_set); // [R5]
  wire [SQ_W-1:0] warn_thr = SQ_W'(warn_lvl) * SQ_W'(gen_set); // [R5]
  wire over_int = (i2_x1000 > int_thr); // [R2]
  wire over_warn = (i2_x1000 > warn_thr);
  wire warn_hold = (CMP_W'(i2_x1000) * CMP_W'(FULL_PCT))
                   >= (CMP_W'(warn_thr) * CMP_W'(WARN_RESET_PCT));
  wire [SQ_W-1:0] i2_sq = SQ_W'(i2_mag) * SQ_W'(i2_mag); // [R1]

  // ==========================================================
  // Integral scale: 100 % equals gen^2 * K in ms
  wire [ACC_W-1:0] k_ms = ACC_W'(k_set) * ACC_W'(MS_PER_TENTH_S);
  wire [ACC_W-1:0] full_scale = ACC_W'(gen_set) * ACC_W'(gen_set) * k_ms; // [R4] [R5]
  wire [ACC_W-1:0] sat_scale = full_scale * ACC_W'(SAT_FACTOR); // [R7]

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] cool_step;
  wire [ACC_W:0] acc_sum = {1'b0, acc} + (ACC_W + 1)'(i2_sq);
  wire [ACC_W-1:0] acc_up = (acc_sum > {1'b0, sat_scale}) ? sat_scale : acc_sum[ACC_W-1:0];
  wire [ACC_W-1:0] acc_down = (acc > cool_step) ? acc - cool_step : '0;
  wire at_full = (acc >= full_scale);
  wire below_reset = (CMP_W'(acc) * CMP_W'(FULL_PCT))
                     < (CMP_W'(full_scale) * CMP_W'(TRIP_RESET_PCT)); // [R8]

  logic [ACC_W-1:0] next_acc;
  always_comb begin
    next_acc = acc;
    if (param_load || !en_set) begin
      next_acc = '0; // [R9] [R12]
    end else if (tick) begin
      next_acc = over_int ? acc_up : acc_down; // [R1] [R2] [R6] [R7]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // ==========================================================
  // Dividers: cooling step and percent readout
  nsi_div_if #(.W(DIV_W)) cool_div ();
  nsi_div_if #(.W(DIV_W)) pct_div ();

  assign cool_div.req = 1'b1;
  assign cool_div.dividend = DIV_W'(full_scale);
  assign cool_div.divisor = DIV_W'(cool_set) * DIV_W'(MS_PER_TENTH_S); // [R6]
  assign pct_div.req = 1'b1;
  assign pct_div.dividend = DIV_W'(acc) * DIV_W'(PER_MILLE); // [R11]
  assign pct_div.divisor = DIV_W'(full_scale);

  nsi_seq_div #(.W(DIV_W)) u_cool_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .div(cool_div.server)
  );

  nsi_seq_div #(.W(DIV_W)) u_pct_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .div(pct_div.server)
  );

  wire cool_big = (cool_div.quotient > DIV_W'({ACC_W{1'b1}}));
  wire cool_zero = (cool_div.quotient == '0);
  wire [ACC_W-1:0] next_step = cool_big ? '1 :
                               cool_zero ? ACC_W'(1) : cool_div.quotient[ACC_W-1:0];
  wire pct_big = (pct_div.quotient > DIV_W'(PCT_MAX));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cool_step <= ACC_W'(1);
      integral_pct <= '0;
    end else begin
      if (cool_div.done) begin
        cool_step <= next_step;
      end
      if (pct_div.done) begin
        integral_pct <= pct_big ? PCT_MAX : pct_div.quotient[PCT_W-1:0]; // [R11]
      end
    end
  end

  // ==========================================================
  // Trip sequencing with definite minimum time
  wire gen_start = gate & over_int; // [R17]
  logic min_done;
  nsi_trip_t state;
  nsi_trip_t next_state;

  nsi_def_timer #(.W(SET_W)) u_min_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(gen_start),
    .tick(tick),
    .limit(min_del),
    .expired(min_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      NSI_IDLE: begin
        if (gen_start) begin
          next_state = NSI_ARMED;
        end
      end
      NSI_ARMED: begin
        if (!gen_start) begin
          next_state = NSI_IDLE;
        end else if (at_full && min_done && !so_set) begin
          next_state = NSI_TRIPPED; // [R3] [R16]
        end
      end
      NSI_TRIPPED: begin
        if (!gate || so_set || below_reset) begin
          next_state = NSI_IDLE; // [R8] [R13] [R14]
        end
      end
      default: begin
        next_state = NSI_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Warning stage, definite time with 0.95 drop-off
  logic warn_act;
  logic warn_done;
  wire next_warn_act = gate & (warn_act ? warn_hold : over_warn); // [R10]

  nsi_def_timer #(.W(SET_W)) u_warn_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(warn_act),
    .tick(tick),
    .limit(warn_del),
    .expired(warn_done)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= NSI_IDLE;
      warn_act <= 1'b0;
      general_start_out <= 1'b0;
      general_trip_out <= 1'b0;
      warning_start_out <= 1'b0;
      warning_trip_out <= 1'b0;
    end else begin
      state <= next_state;
      warn_act <= next_warn_act;
      general_start_out <= gen_start; // [R15] [R17]
      general_trip_out <= (next_state == NSI_TRIPPED); // [R15]
      warning_start_out <= next_warn_act; // [R15]
      warning_trip_out <= gate & warn_act & warn_done; // [R10] [R15]
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  integ_sat_a: assert property (acc <= sat_scale) // [R7]
    else $error("integral above saturation");
  load_clear_a: assert property (param_load |=> acc == '0) // [R9]
    else $error("integral not cleared on load");
  grow_cause_a: assert property (acc > $past(acc) |-> $past(tick && over_int)) // [R2]
    else $error("integral grew without cause");
  cool_linear_a: assert property ( // [R6]
    tick && !over_int && en_set && !param_load && acc > cool_step
    |=> acc == $past(acc) - $past(cool_step))
    else $error("cooling step wrong");
  trip_cause_a: assert property ( // [R16]
    $rose(general_trip_out) |-> $past(at_full && min_done && !so_set && gate))
    else $error("trip without full integral and delay");
  trip_release_a: assert property ( // [R8]
    $fell(general_trip_out) |-> $past(below_reset || !gate || so_set))
    else $error("trip released above reset level");
  start_only_a: assert property (so_set |=> !general_trip_out) // [R13]
    else $error("trip in start-only mode");
  block_out_a: assert property ( // [R14]
    blk_sync |=> !general_start_out && !general_trip_out
                 && !warning_start_out && !warning_trip_out)
    else $error("output while blocked");
  disabled_a: assert property (!en_set |=> acc == '0 && !general_start_out) // [R12]
    else $error("activity while disabled");
  start_level_a: assert property ( // [R17]
    gate && over_int |=> general_start_out ##1 (general_start_out || $past(!gen_start)))
    else $error("start not following threshold");
  warn_order_a: assert property ($rose(warning_trip_out) |-> $past(warn_act)) // [R10]
    else $error("warning without warning start");
  pct_range_a: assert property (integral_pct <= PCT_W'(PER_MILLE * SAT_FACTOR)) // [R11]
    else $error("percent readout out of range");
  trip_hold_a: assert property ( // [R8]
    general_trip_out && gate && !so_set && !below_reset |=> general_trip_out)
    else $error("trip dropped above reset level");
  warn_delay_a: assert property ($rose(warning_trip_out) |-> $past(warn_done && gate)) // [R10]
    else $error("warning before its delay");

  trip_c: cover property ($rose(general_trip_out));
  warn_c: cover property ($rose(warning_trip_out));
  trip_reset_c: cover property ($fell(general_trip_out) && gate);
  block_trip_c: cover property (blk_sync && general_trip_out);
  start_only_c: cover property (so_set && general_start_out);
endmodule : nsi_integrator

/* File: src/nsi_pkg.sv */
// Constants, defaults and types of the negative sequence thermal integrator.
// Assumes a 20 MHz system clock and settings delivered as a loaded set.
// What this block does
// [R1] Integrate squared negative sequence current, keep memory
// [R2] Integrate only above integration start threshold
// [R3] Trip never faster than minimum delay; the free-running tick lets it trip up to one tick early
// [R4] K sets trip time at rated current
// [R5] Thresholds scaled to generator rated current setting
// [R6] Below threshold integral cools linearly over cooling time
// [R7] Integral keeps rising after trip, capped 200%
// [R8] Trip releases only below 90% integral; block, disable and start-only also release it
// [R9] Loading new parameters clears the integral
// [R10] Separate definite-time warning stage
// [R11] Integral percent and all flags readable
// [R12] Enable setting gates everything, off at reset
// [R13] Start-only setting suppresses trip, keeps start
// [R14] Block input disables function and outputs; the integral and integral_pct keep running while blocked
// [R15] Four outputs: start, trip, warning start, warning
// [R16] Trip at 100% after minimum delay, if permitted
// [R17] Start while current above integration threshold
package nsi_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // ==========================================================
  // Widths
  localparam int CUR_W = 16;
  localparam int SET_W = 16;
  localparam int SQ_W = 32;
  localparam int ACC_W = 48;
  localparam int CMP_W = 56;
  localparam int DIV_W = 56;
  localparam int PCT_W = 12;
  // ==========================================================
  // Scaling: currents and levels in 0.1 %, times in 0.1 s or ms
  localparam int PER_MILLE = 1000;
  localparam int MS_PER_TENTH_S = 100;
  localparam int SAT_FACTOR = 2;
  localparam int FULL_PCT = 100;
  localparam int TRIP_RESET_PCT = 90;
  localparam int WARN_RESET_PCT = 95;
  localparam logic [PCT_W-1:0] PCT_MAX = 12'hfff;
  // ==========================================================
  // Setting defaults after reset
  localparam logic ENABLE_RST = 1'b0;
  localparam logic START_ONLY_RST = 1'b0;
  localparam logic [SET_W-1:0] GEN_RATED_RST = 16'h03e8;
  localparam logic [SET_W-1:0] K_RST = 16'h0064;
  localparam logic [SET_W-1:0] COOL_RST = 16'h03e8;
  localparam logic [SET_W-1:0] WARN_LVL_RST = 16'h0028;
  localparam logic [SET_W-1:0] INTEG_LVL_RST = 16'h0032;
  localparam logic [SET_W-1:0] WARN_DEL_RST = 16'h03e8;
  localparam logic [SET_W-1:0] MIN_DEL_RST = 16'h0064;
  // ==========================================================
  // Trip sequencing states
  typedef enum logic [1:0] {
    NSI_IDLE = 2'b00,
    NSI_ARMED = 2'b01,
    NSI_TRIPPED = 2'b10
  } nsi_trip_t;
endpackage : nsi_pkg

/* File: src/nsi_div_if.sv */
// Request and answer bundle between the integrator and its divider.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface nsi_div_if #(parameter int W = 56);
  logic req;
  logic done;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic [W-1:0] quotient;
  modport client (output req, output dividend, output divisor, input done, input quotient);
  modport server (input req, input dividend, input divisor, output done, output quotient);
endinterface : nsi_div_if

/* File: src/nsi_seq_div.sv */
// Restoring divider, one quotient bit per clock, reruns while requested.
// Assumes operands are stable enough that a stale answer is harmless.
`timescale 1ns/1ps
module nsi_seq_div
  import nsi_pkg::*;
#(
  parameter int W = DIV_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Divide request and answer
  nsi_div_if.server div
);
  localparam int CNT_W = $clog2(W + 1);
  logic busy;
  logic [CNT_W-1:0] cnt;
  logic [W-1:0] num;
  logic [W-1:0] den;
  logic [W-1:0] rem;
  logic [W-1:0] quo;
  wire [W:0] shifted = {rem, num[W-1]};
  wire [W:0] diff = shifted - {1'b0, den};
  wire ge = ~diff[W];
  wire last = (cnt == CNT_W'(W - 1));
  wire [W-1:0] next_quo = {quo[W-2:0], ge};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy <= 1'b0;
      cnt <= '0;
      num <= '0;
      den <= '0;
      rem <= '0;
      quo <= '0;
      div.done <= 1'b0;
      div.quotient <= '0;
    end else if (!busy) begin
      div.done <= 1'b0;
      busy <= div.req;
      num <= div.dividend;
      den <= div.divisor;
      rem <= '0;
      quo <= '0;
      cnt <= '0;
    end else begin
      num <= {num[W-2:0], 1'b0};
      rem <= ge ? diff[W-1:0] : shifted[W-1:0];
      quo <= next_quo;
      cnt <= cnt + CNT_W'(1);
      busy <= ~last;
      div.done <= last;
      if (last) begin
        div.quotient <= (den == '0) ? '1 : next_quo;
      end
    end
  end
endmodule : nsi_seq_div

/* File: src/nsi_def_timer.sv */
// Definite-time delay counted in millisecond ticks.
// Assumes tick is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module nsi_def_timer
  import nsi_pkg::*;
#(
  parameter int W = SET_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // Status
  output logic expired
);
  logic [W-1:0] cnt;
  wire reached = (cnt >= limit);
  wire next_expired = run & reached;

  always_ff @(posedge clk_sys) begin
    if (srst || !run) begin
      cnt <= '0;
    end else if (tick && !reached) begin
      cnt <= cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      expired <= 1'b0;
    end else begin
      expired <= next_expired;
    end
  end
endmodule : nsi_def_timer

/* File: bench/nsi_src_model.sv */
// Model of the upstream negative sequence calculator and user blocking logic.
// Assumes commands come from the bench on clk_sys.
`timescale 1ns/1ps
module nsi_src_model
  import nsi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Commands from the bench
  input wire logic [CUR_W-1:0] cmd_level,
  input wire logic cmd_block,
  // Toward the integrator
  output logic [CUR_W-1:0] i2_mag,
  output logic block_input
);
  // ==========================================================
  // One fresh magnitude per clock, like a per-sample result
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      i2_mag <= 16'h0000;
      block_input <= 1'b0;
    end else begin
      i2_mag <= cmd_level;
      block_input <= cmd_block;
    end
  end
endmodule : nsi_src_model

/* File: bench/nsi_integrator_tb.sv */
// Self-checking bench of the negative sequence thermal integrator.
// Assumes a shortened tick of TK clocks; settings K 1.0 s, cooling 1.0 s.
`timescale 1ns/1ps
module nsi_integrator_tb
  import nsi_pkg::*;
;
  localparam int TK = 20;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic param_load = 1'b0;
  logic function_enable_setting = 1'b0;
  logic start_only_setting = 1'b0;
  logic [SET_W-1:0] gen_rated_setting = 16'h03e8;
  logic [SET_W-1:0] k_setting = 16'h000a;
  logic [SET_W-1:0] cooling_time_setting = 16'h000a;
  logic [SET_W-1:0] warn_level_setting = 16'h0028;
  logic [SET_W-1:0] integ_level_setting = 16'h0032;
  logic [SET_W-1:0] warn_delay_setting = 16'h003c;
  logic [SET_W-1:0] min_delay_setting = 16'h0064;
  logic [CUR_W-1:0] cmd_level = 16'h0000;
  logic cmd_block = 1'b0;
  logic [CUR_W-1:0] i2_mag;
  logic block_input;
  logic general_start_out, general_trip_out, warning_start_out, warning_trip_out;
  logic [PCT_W-1:0] integral_pct;
  int bad_count = 0;
  int n_checks = 0;
  int n;

  nsi_src_model u_nsi_src_model (.clk_sys, .srst, .cmd_level, .cmd_block, .i2_mag,
    .block_input);
  nsi_integrator #(.TICK_CYCLES(TK)) u_nsi_integrator (.clk_sys, .srst, .i2_mag,
    .block_input, .param_load, .function_enable_setting, .start_only_setting,
    .gen_rated_setting, .k_setting, .cooling_time_setting, .warn_level_setting,
    .integ_level_setting, .warn_delay_setting, .min_delay_setting, .general_start_out,
    .general_trip_out, .warning_start_out, .warning_trip_out, .integral_pct);

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("Checks made %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %0b seen %0b", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    n_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      bad_count++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic load(input logic en, input logic so, input logic [15:0] gen, md);
    @(posedge clk_sys);
    param_load <= 1'b1;
    function_enable_setting <= en;
    start_only_setting <= so;
    gen_rated_setting <= gen;
    min_delay_setting <= md;
    @(posedge clk_sys);
    param_load <= 1'b0;
    #1;
  endtask : load

  task automatic level(input logic [15:0] v, input logic b);
    @(posedge clk_sys);
    cmd_level <= v;
    cmd_block <= b;
  endtask : level

  task automatic wait_trip(input logic v, input int lim, output int c);
    c = 0;
    while (general_trip_out !== v && c < lim) begin
      step(1);
      c++;
    end
    if (c >= lim) begin
      bad_count++;
      $display("Error trip wait expected %0b seen %0b", v, general_trip_out);
      summarize();
    end
  endtask : wait_trip

  // ==========================================================
  // Scenarios
  task automatic s_reset_off();
    level(16'h4e20, 1'b0);
    step(10 * TK);
    chk("start", 1'b0, general_start_out);
    chk("trip", 1'b0, general_trip_out);
    chk("warn start", 1'b0, warning_start_out);
    chk("warn trip", 1'b0, warning_trip_out);
    chk_rng("integral", 0, 0, 32'(integral_pct));
  endtask : s_reset_off

  task automatic s_warning();
    // Level first, so the enabling load never meets the large current
    level(16'h002d, 1'b0);
    load(1'b1, 1'b0, 16'h03e8, 16'h0064);
    step(4);
    chk("warn start", 1'b1, warning_start_out);
    chk("start", 1'b0, general_start_out);
    step(54 * TK);
    chk("warn trip early", 1'b0, warning_trip_out);
    chk_rng("integral", 0, 0, 32'(integral_pct));
    step(10 * TK);
    chk("warn trip", 1'b1, warning_trip_out);
    level(16'h0000, 1'b0);
    step(4);
    chk("warn drop", 1'b0, warning_start_out);
    chk("warn trip drop", 1'b0, warning_trip_out);
  endtask : s_warning

  task automatic s_rate_cool();
    load(1'b1, 1'b0, 16'h01f4, 16'h003c);
    level(16'h03e8, 1'b0);
    step(3);
    chk("start", 1'b1, general_start_out);
    wait_trip(1'b1, 300 * TK, n);
    chk_rng("trip cycles", 245 * TK, 252 * TK, 32'(n));
    step(300 * TK);
    chk_rng("cap", 2000, 2000, 32'(integral_pct));
    level(16'h0000, 1'b0);
    step(3);
    chk("start off", 1'b0, general_start_out);
    wait_trip(1'b0, 1200 * TK, n);
    chk_rng("cool cycles", 1095 * TK, 1112 * TK, 32'(n));
    // Readout lags the integral by up to two divider runs
    step(6 * TK);
    chk_rng("release", 880, 900, 32'(integral_pct));
    load(1'b1, 1'b0, 16'h01f4, 16'h003c);
    step(200);
    chk_rng("cleared", 0, 0, 32'(integral_pct));
  endtask : s_rate_cool

  task automatic s_min_time();
    load(1'b1, 1'b0, 16'h03e8, 16'h0064);
    level(16'h4e20, 1'b0);
    step(3);
    wait_trip(1'b1, 200 * TK, n);
    chk_rng("min delay", 99 * TK, 103 * TK, 32'(n));
  endtask : s_min_time

  task automatic s_start_only_block();
    // Block while trip and warning stand from the previous scenario
    level(16'h4e20, 1'b1);
    step(6);
    chk("blk start", 1'b0, general_start_out);
    chk("blk warn", 1'b0, warning_start_out);
    chk("blk warn trip", 1'b0, warning_trip_out);
    chk("blk trip", 1'b0, general_trip_out);
    level(16'h4e20, 1'b0);
    load(1'b1, 1'b1, 16'h03e8, 16'h0064);
    step(150 * TK);
    chk("start", 1'b1, general_start_out);
    chk("trip", 1'b0, general_trip_out);
    chk("so warn trip", 1'b1, warning_trip_out);
    load(1'b0, 1'b0, 16'h03e8, 16'h0064);
    step(200);
    chk("off start", 1'b0, general_start_out);
    chk("off warn", 1'b0, warning_start_out);
    chk_rng("off integral", 0, 0, 32'(integral_pct));
    level(16'h0000, 1'b0);
  endtask : s_start_only_block

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    s_reset_off();
    s_warning();
    s_rate_cool();
    s_min_time();
    s_start_only_block();
    summarize();
  end
endmodule : nsi_integrator_tb
